// ### pkg/ssc_defs.vh
// Constants shared by the serial control and status block
`ifndef SSC_DEFS_VH
`define SSC_DEFS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define SSC_ADDR_CTRL 8'h1F
`define SSC_ADDR_STAT 8'h20
`define SSC_ADDR_BUF 8'h21

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SSC_CR_EDG 7
`define SSC_CR_CKS_HI 6
`define SSC_CR_CKS_LO 4
`define SSC_CR_DIR 3
`define SSC_CR_START 2
`define SSC_CR_MODE_HI 1
`define SSC_CR_MODE_LO 0

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define SSC_SR_XFER 7
`define SSC_SR_SHIFT 6
`define SSC_SR_OVR 5
`define SSC_SR_RXDONE 4
`define SSC_SR_UNDR 3
`define SSC_SR_TBFULL 2
`define SSC_SR_ZERO 2'h0

// ----------------------------------------
// Modes and clock codes
// ----------------------------------------
`define SSC_MODE_STOP 2'h0
`define SSC_MODE_TX 2'h1
`define SSC_MODE_RX 2'h2
`define SSC_MODE_TRX 2'h3
`define SSC_MODE_TX_BIT 0
`define SSC_MODE_RX_BIT 1
`define SSC_CKS_D512 3'h0
`define SSC_CKS_D64 3'h1
`define SSC_CKS_D32 3'h2
`define SSC_CKS_D16 3'h3
`define SSC_CKS_D8 3'h4
`define SSC_CKS_D4 3'h5
`define SSC_CKS_D2 3'h6
`define SSC_CKS_EXT 3'h7
`define SSC_CKS_SLOW 3'h6

// ----------------------------------------
// Half periods of the serial clock in clock cycles
// ----------------------------------------
`define SSC_HALF_D512 9'h100
`define SSC_HALF_D64 9'h020
`define SSC_HALF_D32 9'h010
`define SSC_HALF_D16 9'h008
`define SSC_HALF_D8 9'h004
`define SSC_HALF_D4 9'h002
`define SSC_HALF_D2 9'h001
`define SSC_HALF_SLOW 9'h004

// ----------------------------------------
// Byte framing and reset values
// ----------------------------------------
`define SSC_LAST_BIT 3'h7
`define SSC_FIRST_BIT 3'h0
`define SSC_BYTE_ZERO 8'h00

`endif

// ### verilog/ssc_sync.v
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
`default_nettype none

module ssc_sync
(
    // Clock and reset
    input wire clk_i,
    input wire nrst_i,
    // Pin and filtered result
    input wire d_i,
    output reg level_o,
    output reg rise_o,
    output reg fall_o
);

reg ff1;
reg ff2;
reg ff3;

// ----------------------------------------
// Capture and agreement
// ----------------------------------------
always @(posedge clk_i)
begin
    if (!nrst_i)
    begin
        ff1 <= 1'b0;
        ff2 <= 1'b0;
        ff3 <= 1'b0;
        level_o <= 1'b0;
        rise_o <= 1'b0;
        fall_o <= 1'b0;
    end
    else
    begin
        ff1 <= d_i;
        ff2 <= ff1;
        ff3 <= ff2;
        rise_o <= 1'b0;
        fall_o <= 1'b0;
        if ((ff2 == ff3) && (ff3 != level_o))
        begin
            level_o <= ff3;
            rise_o <= ff3;
            fall_o <= ~ff3;
        end
    end
end

endmodule // ssc_sync
`default_nettype wire

// ### verilog/ssc_clkgen.v
// Internal serial clock divider with edge pulses
`timescale 1ns/10ps
`default_nettype none
`include "ssc_defs.vh"

module ssc_clkgen
(
    // Clock and reset
    input wire clk_i,
    input wire nrst_i,
    // Control
    input wire run_i,
    input wire [2:0] cks_i,
    input wire slow_i,
    input wire idle_i,
    // Serial clock and edges
    output reg sclk_o,
    output reg rise_o,
    output reg fall_o
);

reg [8:0] cnt;
wire [8:0] half;

// ----------------------------------------
// Half period lookup
// ----------------------------------------
function [8:0] half_of;
    input [2:0] code;
    input slow;
    begin
        if (slow)
            half_of = `SSC_HALF_SLOW;
        else
        begin
            case (code)
                `SSC_CKS_D512: half_of = `SSC_HALF_D512;
                `SSC_CKS_D64: half_of = `SSC_HALF_D64;
                `SSC_CKS_D32: half_of = `SSC_HALF_D32;
                `SSC_CKS_D16: half_of = `SSC_HALF_D16;
                `SSC_CKS_D8: half_of = `SSC_HALF_D8;
                `SSC_CKS_D4: half_of = `SSC_HALF_D4;
                default: half_of = `SSC_HALF_D2;
            endcase
        end
    end
endfunction

assign half = half_of(cks_i, slow_i);

// ----------------------------------------
// Divider
// ----------------------------------------
always @(posedge clk_i)
begin
    if (!nrst_i)
    begin
        cnt <= 9'h000;
        sclk_o <= 1'b1;
        rise_o <= 1'b0;
        fall_o <= 1'b0;
    end
    else
    begin
        rise_o <= 1'b0;
        fall_o <= 1'b0;
        if (!run_i)
        begin
            cnt <= 9'h000;
            sclk_o <= idle_i;
        end
        else if (cnt == (half - 9'h001))
        begin
            cnt <= 9'h000;
            sclk_o <= ~sclk_o;
            rise_o <= ~sclk_o;
            fall_o <= sclk_o;
        end
        else
            cnt <= cnt + 9'h001;
    end
end

endmodule // ssc_clkgen
`default_nettype wire

// ### verilog/ssc_top.v
// Control, status and byte engine of the clock-synchronous serial interface
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "ssc_defs.vh"

module ssc_top
(
    // Clock and reset
    input wire clk_i,
    input wire nrst_i,
    // Register port
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // Power mode inputs
    input wire deep_lp_i,
    input wire slow_mode_i,
    // Serial pins
    input wire sclk_i,
    output wire sclk_o,
    output reg sclk_oe_o,
    input wire sdi_i,
    output reg sdo_o,
    // Interface interrupt request
    output reg irq_o
);

// ----------------------------------------
// Declarations
// ----------------------------------------
reg edg;
reg [2:0] cks;
reg dir;
reg start;
reg [1:0] mode;
reg xfer;
reg shifting;
reg receive_overrun_flag;
reg receive_complete_flag;
reg transmit_underrun_flag;
reg transmit_buffer_full;
reg [7:0] txbuf;
reg [7:0] rxbuf;
reg [7:0] shreg;
reg [7:0] rxsh;
reg [2:0] bitcnt;
reg [7:0] next_rdata;
wire wr_ctrl;
wire wr_buf;
wire rd_stat;
wire rd_buf;
wire [1:0] w_mode;
wire w_start;
wire forced_stop;
wire start_go;
wire int_clk;
wire clk_ok;
wire run;
wire c_rise;
wire c_fall;
wire x_rise;
wire x_fall;
wire sdi_s;
wire e_rise;
wire e_fall;
wire drive_ev;
wire samp_ev;
wire tx_mode;
wire rx_mode;
wire [7:0] next_rxsh;
wire [7:0] ctrl_word;
wire [7:0] stat_word;

// ----------------------------------------
// Helpers
// ----------------------------------------
function tx_bit;
    input [7:0] d;
    input [2:0] idx;
    input msb;
    begin
        if (msb)
            tx_bit = d[`SSC_LAST_BIT - idx];
        else
            tx_bit = d[idx];
    end
endfunction

function match;
    input [7:0] a;
    input [7:0] b;
    begin
        match = (a == b);
    end
endfunction

// ----------------------------------------
// Register decode
// ----------------------------------------
assign wr_ctrl = wr_i && match(addr_i, `SSC_ADDR_CTRL);
assign wr_buf = wr_i && match(addr_i, `SSC_ADDR_BUF);
assign rd_stat = rd_i && match(addr_i, `SSC_ADDR_STAT);
assign rd_buf = rd_i && match(addr_i, `SSC_ADDR_BUF);
assign w_mode = wdata_i[`SSC_CR_MODE_HI:`SSC_CR_MODE_LO];
assign w_start = wdata_i[`SSC_CR_START];

// Stop by write of mode 00 or by deep low power entry
assign forced_stop = (wr_ctrl && (w_mode == `SSC_MODE_STOP)) || deep_lp_i;

// Start on a 0 to 1 change with a non-stop mode
assign start_go = wr_ctrl && !xfer && !start && w_start && (w_mode != `SSC_MODE_STOP) && !deep_lp_i;

assign tx_mode = mode[`SSC_MODE_TX_BIT];
assign rx_mode = mode[`SSC_MODE_RX_BIT];

// ----------------------------------------
// Control register
// ----------------------------------------
always @(posedge clk_i)
begin
    if (!nrst_i)
    begin
        edg <= 1'b0;
        cks <= `SSC_CKS_D512;
        dir <= 1'b0;
        start <= 1'b0;
        mode <= `SSC_MODE_STOP;
    end
    else if (deep_lp_i)
    begin
        // Settings other than mode and start are kept
        mode <= `SSC_MODE_STOP;
        start <= 1'b0;
    end
    else if (wr_ctrl)
    begin
        if (!xfer)
        begin
            edg <= wdata_i[`SSC_CR_EDG];
            cks <= wdata_i[`SSC_CR_CKS_HI:`SSC_CR_CKS_LO];
            dir <= wdata_i[`SSC_CR_DIR];
            mode <= w_mode;
            start <= w_start && (w_mode != `SSC_MODE_STOP);
        end
        else if (w_mode == `SSC_MODE_STOP)
        begin
            mode <= `SSC_MODE_STOP;
            start <= 1'b0;
        end
        else if (!w_start)
            start <= 1'b0;
    end
end

// ----------------------------------------
// Serial clock sources
// ----------------------------------------
assign int_clk = (cks != `SSC_CKS_EXT);
assign clk_ok = !slow_mode_i || (cks == `SSC_CKS_SLOW);
assign run = xfer && shifting && int_clk && clk_ok;

ssc_clkgen u_clkgen
(
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .run_i(run),
    .cks_i(cks),
    .slow_i(slow_mode_i),
    .idle_i(start_go ? ~wdata_i[`SSC_CR_EDG] : ~edg),
    .sclk_o(sclk_o),
    .rise_o(c_rise),
    .fall_o(c_fall)
);

ssc_sync u_sync_sclk
(
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i(sclk_i),
    .level_o(),
    .rise_o(x_rise),
    .fall_o(x_fall)
);

ssc_sync u_sync_sdi
(
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i(sdi_i),
    .level_o(sdi_s),
    .rise_o(),
    .fall_o()
);

assign e_rise = int_clk ? c_rise : x_rise;
assign e_fall = int_clk ? c_fall : x_fall;

// Drive and sample edges swap with the edge bit
assign drive_ev = xfer && shifting && clk_ok && (edg ? e_rise : e_fall);
assign samp_ev = xfer && shifting && clk_ok && (edg ? e_fall : e_rise);

// Receive shifter in the selected bit order
assign next_rxsh = dir ? {rxsh[6:0], sdi_s} : {sdi_s, rxsh[7:1]};

// ----------------------------------------
// Byte engine and status flags
// ----------------------------------------
always @(posedge clk_i)
begin
    if (!nrst_i)
    begin
        xfer <= 1'b0;
        shifting <= 1'b0;
        receive_overrun_flag <= 1'b0;
        receive_complete_flag <= 1'b0;
        transmit_underrun_flag <= 1'b0;
        transmit_buffer_full <= 1'b0;
        txbuf <= `SSC_BYTE_ZERO;
        rxbuf <= `SSC_BYTE_ZERO;
        shreg <= `SSC_BYTE_ZERO;
        rxsh <= `SSC_BYTE_ZERO;
        bitcnt <= `SSC_FIRST_BIT;
        sdo_o <= 1'b0;
        irq_o <= 1'b0;
    end
    else
    begin
        irq_o <= 1'b0;
        // Clears first so that a later set in this cycle wins
        if (rd_stat)
        begin
            receive_overrun_flag <= 1'b0;
            transmit_underrun_flag <= 1'b0;
        end
        if (rd_buf)
            receive_complete_flag <= 1'b0;
        if (wr_buf)
        begin
            if (xfer && !shifting && tx_mode && start)
            begin
                // Empty shifter takes the byte at once
                shreg <= wdata_i;
                shifting <= 1'b1;
                bitcnt <= `SSC_FIRST_BIT;
            end
            else
            begin
                txbuf <= wdata_i;
                transmit_buffer_full <= xfer;
            end
        end
        if (forced_stop)
        begin
            xfer <= 1'b0;
            shifting <= 1'b0;
            receive_overrun_flag <= 1'b0;
            receive_complete_flag <= 1'b0;
            transmit_underrun_flag <= 1'b0;
            transmit_buffer_full <= 1'b0;
            bitcnt <= `SSC_FIRST_BIT;
        end
        else if (start_go)
        begin
            xfer <= 1'b1;
            shifting <= 1'b1;
            irq_o <= 1'b1;
            shreg <= txbuf;
            transmit_buffer_full <= 1'b0;
            bitcnt <= `SSC_FIRST_BIT;
        end
        else if (xfer)
        begin
            if (drive_ev && tx_mode)
                sdo_o <= tx_bit(shreg, bitcnt, dir);
            if (samp_ev)
            begin
                if (rx_mode)
                    rxsh <= next_rxsh;
                bitcnt <= bitcnt + 3'h1;
                if (bitcnt == `SSC_LAST_BIT)
                begin
                    shifting <= 1'b0;
                    bitcnt <= `SSC_FIRST_BIT;
                    irq_o <= 1'b1;
                    if (rx_mode)
                    begin
                        rxbuf <= next_rxsh;
                        receive_complete_flag <= 1'b1;
                        if (receive_complete_flag && !rd_buf)
                            receive_overrun_flag <= 1'b1;
                    end
                    if (!start)
                        xfer <= 1'b0;
                    else if (tx_mode)
                    begin
                        if (transmit_buffer_full)
                        begin
                            shreg <= txbuf;
                            transmit_buffer_full <= wr_buf;
                            shifting <= 1'b1;
                        end
                        else
                            transmit_underrun_flag <= 1'b1;
                    end
                    else
                        shifting <= 1'b1;
                end
            end
            else if (!start && !shifting)
                xfer <= 1'b0;
        end
    end
end

// ----------------------------------------
// Read data
// ----------------------------------------
assign ctrl_word = {edg, cks, dir, start, mode};
assign stat_word = {xfer, shifting, receive_overrun_flag, receive_complete_flag, transmit_underrun_flag, transmit_buffer_full, `SSC_SR_ZERO};

always @*
begin
    next_rdata = `SSC_BYTE_ZERO;
    if (rd_i)
    begin
        if (match(addr_i, `SSC_ADDR_CTRL))
            next_rdata = ctrl_word;
        else if (match(addr_i, `SSC_ADDR_STAT))
            next_rdata = stat_word;
        else if (match(addr_i, `SSC_ADDR_BUF))
            next_rdata = rxbuf;
    end
end

always @(posedge clk_i)
begin
    if (!nrst_i)
    begin
        rdata_o <= `SSC_BYTE_ZERO;
        sclk_oe_o <= 1'b0;
    end
    else
    begin
        rdata_o <= next_rdata;
        sclk_oe_o <= int_clk;
    end
end

endmodule // ssc_top
`default_nettype wire

// ### tb/ssc_top_monitor.sv
// Port assertions for the serial control block
`timescale 1ns/10ps
`default_nettype none
module ssc_top_monitor
(
    // Clock and reset
    input wire clk_i,
    input wire nrst_i,
    // Register port
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    // Power and serial
    input wire deep_lp_i,
    input wire sclk_o,
    input wire sdo_o,
    input wire irq_o
);
    logic idle_h;
    wire wr_ctrl = wr_i && addr_i == 8'h1F;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    // Known idle after reset or any forced stop
    always @(posedge clk_i)
    begin
        if (!nrst_i || deep_lp_i || (wr_ctrl && wdata_i[1:0] == 2'h0))
            idle_h <= 1'b1;
        else if (wr_ctrl && wdata_i[2])
            idle_h <= 1'b0;
    end
    sequence s_start;
        wr_ctrl && wdata_i[2] && wdata_i[1:0] != 2'h0 && idle_h && !deep_lp_i;
    endsequence
    sequence s_fstop;
        wr_ctrl && wdata_i[1:0] == 2'h0;
    endsequence
    sequence s_rd(logic [7:0] a);
        rd_i && addr_i == a;
    endsequence
    a_start_irq: assert property (s_start |=> irq_o)
        else $error("no request pulse after start");
    a_irq_pulse: assert property (irq_o |=> !irq_o)
        else $error("request pulse too long");
    a_fstop_stat: assert property (s_fstop ##[1:4] s_rd(8'h20) |=> rdata_o == 8'h00)
        else $error("status not cleared by stop");
    a_fstop_start: assert property (s_fstop ##[1:4] s_rd(8'h1F) |=> rdata_o[2:0] == 3'h0)
        else $error("start or mode not zero after stop");
    a_deep_quiet: assert property (deep_lp_i [*2] |=> !irq_o ##1 $stable(sclk_o))
        else $error("activity in deep low power");
    a_stat_zero: assert property (s_rd(8'h20) |=> rdata_o[1:0] == 2'h0)
        else $error("status low bits not zero");
    a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    a_unmapped_rd: assert property (rd_i && (addr_i < 8'h1F || addr_i > 8'h21) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_sdo_edge: assert property ($changed(sdo_o) |-> $past(sclk_o) != $past(sclk_o, 2))
        else $error("data out moved off a clock edge");
endmodule // ssc_top_monitor
bind ssc_top ssc_top_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .deep_lp_i(deep_lp_i), .sclk_o(sclk_o), .sdo_o(sdo_o),
    .irq_o(irq_o));
`default_nettype wire

// ### tb/ssc_peer.sv
// Serial peer that sends and collects one byte pattern
`timescale 1ns/10ps
`default_nettype none
module ssc_peer
(
    // Clock and control
    input wire logic clk_i,
    input wire logic restart_i,
    input wire logic edge_i,
    input wire logic msb_i,
    input wire logic [7:0] tx_i,
    // Serial pins
    input wire logic sclk_i,
    input wire logic sdo_i,
    output logic sdi_o,
    output logic [7:0] rx_o
);
    logic sclk_q;
    logic [2:0] dcnt;
    logic [2:0] scnt;
    logic [5:0] quiet;
    wire chg = sclk_q != sclk_i;
    always @(posedge clk_i)
    begin
        sclk_q <= sclk_i;
        quiet <= chg ? 6'h00 : quiet + 6'h01;
        if (restart_i)
        begin
            dcnt <= 3'h0;
            scnt <= 3'h0;
            sdi_o <= 1'b0;
            quiet <= 6'h00;
        end
        else
        begin
            if (chg && sclk_i == edge_i)
            begin
                sdi_o <= tx_i[msb_i ? 3'h7 - dcnt : dcnt];
                dcnt <= dcnt + 3'h1;
            end
            else if (quiet == 6'h3F) // Unused line wanders
                sdi_o <= ~sdi_o;
            if (chg && sclk_i != edge_i)
            begin
                rx_o[msb_i ? 3'h7 - scnt : scnt] <= sdo_i;
                scnt <= scnt + 3'h1;
            end
        end
    end
endmodule // ssc_peer
`default_nettype wire

// ### tb/test_ssc_top.sv
// Register level test of the serial control block
`timescale 1ns/10ps
`default_nettype none
module test_ssc_top;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic deep_lp_i = 1'b0;
    logic restart = 1'b1;
    logic [7:0] peer_tx = 8'h00;
    logic [7:0] ctrl = 8'h00;
    logic [7:0] b0;
    wire [7:0] rdata_o;
    wire sclk_o;
    wire sdo_o;
    wire sdi;
    wire sclk_oe;
    wire irq_o;
    wire [7:0] peer_rx;
    int n_errors = 0;
    int total_checks = 0;
    ssc_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .deep_lp_i(deep_lp_i), .slow_mode_i(1'b0), .sclk_i(1'b0),
        .sclk_o(sclk_o), .sclk_oe_o(sclk_oe), .sdi_i(sdi), .sdo_o(sdo_o), .irq_o(irq_o));
    ssc_peer u_peer (.clk_i(clk_i), .restart_i(restart), .edge_i(ctrl[7]), .msb_i(ctrl[3]),
        .tx_i(peer_tx), .sclk_i(sclk_o), .sdo_i(sdo_o), .sdi_o(sdi), .rx_o(peer_rx));
    initial
    begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(name, exp, rdata_o);
    endtask
    task automatic wait_irq();
        int k;
        k = 0;
        @(posedge clk_i);
        #1;
        while (irq_o !== 1'b1 && k < 400)
        begin
            @(posedge clk_i);
            #1 k++;
        end
        if (k == 400)
            chk("irq wait", 8'h01, 8'h00);
        @(posedge clk_i);
        #1;
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        finish_test();
    end
    initial
    begin
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(8'h1F, 8'h00, "ctrl reset");
        rd(8'h20, 8'h00, "stat reset");
        rd(8'h21, 8'h00, "buf reset");
        rd(8'h22, 8'h00, "unmapped");
        chk("clock drive", 8'h01, {7'h00, sclk_oe});
        for (int i = 0; i < 2; i++)
        begin
            b0 = 8'h35 ^ {8{i[0]}};
            peer_tx <= i ? 8'h4B : 8'hA6;
            ctrl <= {i[0], 3'h3, i[0], 1'b1, 2'h3};
            wr(8'h21, b0);
            wr(8'h1F, ctrl);
            restart <= 1'b1;
            repeat (3) @(posedge clk_i);
            restart <= 1'b0;
            rd(8'h20, 8'hC0, "busy shifting");
            wr(8'h1F, {~i[0], 3'h0, ~i[0], 1'b1, 2'h1});
            rd(8'h1F, ctrl, "ctrl locked");
            wr(8'h21, ~b0);
            rd(8'h20, 8'hC4, "tx full");
            wait_irq();
            rd(8'h20, 8'hD0, "byte one");
            wait_irq();
            rd(8'h20, 8'hB8, "ovr undr");
            rd(8'h20, 8'h90, "read clear");
            chk("peer rx", ~b0, peer_rx);
            rd(8'h21, peer_tx, "rx byte");
            rd(8'h20, 8'h80, "rx done clr");
            wr(8'h1F, ctrl & 8'hFB);
            rd(8'h20, 8'h00, "orderly stop");
            wr(8'h1F, (ctrl & 8'hFC) | 8'h02);
            wait_irq();
            wr(8'h1F, ctrl & 8'hFC);
            rd(8'h1F, ctrl & 8'hF8, "forced ctrl");
            rd(8'h20, 8'h00, "forced stat");
            rd(8'h21, peer_tx, "rx mode byte");
            wr(8'h21, b0);
            wr(8'h1F, (ctrl & 8'hFC) | 8'h01);
            @(posedge clk_i);
            deep_lp_i <= 1'b1;
            rd(8'h20, 8'h00, "deep stat");
            deep_lp_i <= 1'b0;
            rd(8'h1F, ctrl & 8'hF8, "deep ctrl");
            $display("test %0d done", i);
        end
        finish_test();
    end
endmodule // test_ssc_top
`default_nettype wire
